//--- nnp_pkg.sv
// Shared constants and types for the negate, no-operation and pop execution block.
// Function
// - Accumulator negate replaces selected accumulator with negation
// - Accumulator negate uses all 40 bits, unsaturated
// - File pop decrements stack pointer by two first
// - Popped stack top word goes to file register
// - Pop destination lies within lower 32K data words
package nnp_pkg;

  localparam int NNP_DATA_W = 16;
  localparam int NNP_ACC_W = 40;
  localparam int NNP_BYTE_W = 8;
  localparam int NNP_FLAG_W = 5;

  // Stack pointer moves by one word, which is two byte addresses.
  localparam logic [15:0] NNP_SP_STEP = 16'h0002;
  // File register addresses are word aligned byte addresses below 64K bytes.
  localparam logic [15:0] NNP_FILE_ADDR_MASK = 16'hFFFE;

  // Positions of the flags in the flag bus.
  localparam int NNP_FLAG_C = 0;
  localparam int NNP_FLAG_Z = 1;
  localparam int NNP_FLAG_OV = 2;
  localparam int NNP_FLAG_N = 3;
  localparam int NNP_FLAG_DC = 4;

  // Reset values.
  localparam logic [15:0] NNP_RST_WORD = 16'h0000;
  localparam logic [39:0] NNP_RST_ACC = 40'h00_0000_0000;
  localparam logic [4:0] NNP_RST_FLAGS = 5'h00;

  typedef enum logic [2:0] {
    NNP_OP_NOP = 3'b000,
    NNP_OP_NOPR = 3'b001,
    NNP_OP_NEG_W = 3'b010,
    NNP_OP_NEG_ACC = 3'b011,
    NNP_OP_POP_F = 3'b100,
    NNP_OP_POP_W = 3'b101
  } nnp_op_e;

  typedef enum logic [1:0] {
    NNP_ST_IDLE = 2'b00,
    NNP_ST_READ = 2'b01,
    NNP_ST_WAIT = 2'b10
  } nnp_state_e;

endpackage : nnp_pkg

//--- nnp_negate.sv
// Two's complement negation of a word with the arithmetic flags of 0 minus value.
`timescale 1ns/100ps
module nnp_negate #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] val, // Operand to negate.
  output logic [WIDTH-1:0] res, // Negated operand.
  output logic c_flag, // No borrow: set only when the operand is zero.
  output logic dc_flag, // No borrow out of the low nibble.
  output logic n_flag, // Result sign bit.
  output logic ov_flag, // Signed overflow: operand was the most negative value.
  output logic z_flag // Result is zero.
);

  // The half carry flag looks at the low nibble, so narrower words cannot be served.
  if (WIDTH < 5) begin : g_width_check
    $error("nnp_negate needs at least five bits");
  end

  // Subtracting from zero borrows unless the operand is zero, so C and DC test for zero.
  assign res = WIDTH'(~val + 1'b1);
  assign c_flag = (val == '0);
  assign dc_flag = (val[3:0] == 4'h0);
  assign n_flag = res[WIDTH-1];
  assign ov_flag = val[WIDTH-1] & res[WIDTH-1];
  assign z_flag = (res == '0);

endmodule // nnp_negate

//--- nnp_exec.sv
// Execution unit for the negate, no-operation and stack pop instruction group.
`timescale 1ns/100ps
module nnp_exec (
  input wire logic core_clk, // Core clock, 100 MHz.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic op_valid, // One-cycle pulse: an instruction is issued.
  input wire nnp_pkg::nnp_op_e op_code, // Instruction of this group.
  input wire logic byte_mode, // Byte size for register negate.
  input wire logic [nnp_pkg::NNP_DATA_W-1:0] source_working_reg, // Negate operand.
  input wire logic acc_sel_b, // Accumulator select: 0 is A, 1 is B.
  input wire logic [nnp_pkg::NNP_ACC_W-1:0] accumulator_a, // Accumulator A value.
  input wire logic [nnp_pkg::NNP_ACC_W-1:0] accumulator_b, // Accumulator B value.
  input wire logic [nnp_pkg::NNP_DATA_W-1:0] file_addr, // Pop destination byte address.
  input wire logic [nnp_pkg::NNP_DATA_W-1:0] stack_pointer_register, // Stack pointer.
  input wire logic [nnp_pkg::NNP_DATA_W-1:0] mem_rdata, // Data memory read word.
  input wire logic mem_rvalid, // Read data valid pulse.
  output logic busy, // A pop is in progress; new issues are ignored.
  output logic done, // One-cycle pulse when an instruction completes.
  output logic dest_we, // Write pulse to the destination working register.
  output logic dest_byte, // Destination write covers the low byte only.
  output logic [nnp_pkg::NNP_DATA_W-1:0] dest_working_reg, // Destination write data.
  output logic flags_we, // Write pulse for the flag bus.
  output logic [nnp_pkg::NNP_FLAG_W-1:0] flags, // DC, N, OV, Z, C.
  output logic acc_a_we, // Write pulse to accumulator A.
  output logic acc_b_we, // Write pulse to accumulator B.
  output logic [nnp_pkg::NNP_ACC_W-1:0] acc_wdata, // Accumulator write data.
  output logic sp_we, // Write pulse to the stack pointer.
  output logic [nnp_pkg::NNP_DATA_W-1:0] sp_wdata, // New stack pointer.
  output logic mem_re, // Data memory read pulse.
  output logic [nnp_pkg::NNP_DATA_W-1:0] mem_raddr, // Read address, the stack top.
  output logic mem_we, // Data memory write pulse.
  output logic [nnp_pkg::NNP_DATA_W-1:0] mem_waddr, // File register write address.
  output logic [nnp_pkg::NNP_DATA_W-1:0] mem_wdata // Popped stack top word.
);
  import nnp_pkg::*;

  nnp_state_e state_r, state_nxt;
  logic pop_file_r;
  logic [NNP_DATA_W-1:0] faddr_r;
  logic busy_r, done_r, dest_we_r, dest_byte_r, flags_we_r, acc_a_we_r, acc_b_we_r;
  logic sp_we_r, mem_re_r, mem_we_r;
  logic [NNP_DATA_W-1:0] dest_r, sp_r, raddr_r, waddr_r, wdata_r;
  logic [NNP_FLAG_W-1:0] flags_r;
  logic [NNP_ACC_W-1:0] acc_r;

  wire logic [NNP_DATA_W-1:0] neg16;
  wire logic [NNP_BYTE_W-1:0] neg8;
  wire logic [NNP_ACC_W-1:0] neg40;
  wire logic c16, dc16, n16, ov16, z16;
  wire logic c8, dc8, n8, ov8, z8;

  // Word and byte negation share the operand; only the chosen size is written back.
  nnp_negate #(.WIDTH(NNP_DATA_W)) u_neg_word (
    .val(source_working_reg),
    .res(neg16),
    .c_flag(c16),
    .dc_flag(dc16),
    .n_flag(n16),
    .ov_flag(ov16),
    .z_flag(z16)
  );

  nnp_negate #(.WIDTH(NNP_BYTE_W)) u_neg_byte (
    .val(source_working_reg[NNP_BYTE_W-1:0]),
    .res(neg8),
    .c_flag(c8),
    .dc_flag(dc8),
    .n_flag(n8),
    .ov_flag(ov8),
    .z_flag(z8)
  );

  // The accumulator result is kept at full width with no saturation, so a
  // negated most negative value wraps instead of clipping.
  wire logic [NNP_ACC_W-1:0] acc_src = acc_sel_b ? accumulator_b : accumulator_a;
  nnp_negate #(.WIDTH(NNP_ACC_W)) u_neg_acc (
    .val(acc_src),
    .res(neg40),
    .c_flag(),
    .dc_flag(),
    .n_flag(),
    .ov_flag(),
    .z_flag()
  );

  // Issue decode; an issue while a pop runs is dropped.
  wire logic issue = op_valid & (state_r == NNP_ST_IDLE);
  wire logic do_neg_w = issue & (op_code == NNP_OP_NEG_W);
  wire logic do_neg_acc = issue & (op_code == NNP_OP_NEG_ACC);
  wire logic do_nop = issue & ((op_code == NNP_OP_NOP) | (op_code == NNP_OP_NOPR));
  wire logic do_pop = issue & ((op_code == NNP_OP_POP_F) | (op_code == NNP_OP_POP_W));
  wire logic pop_end = (state_r == NNP_ST_WAIT) & mem_rvalid;

  // Pre-decremented stack pointer; it becomes the read address of the stack top.
  wire logic [NNP_DATA_W-1:0] sp_dec = NNP_DATA_W'(stack_pointer_register - NNP_SP_STEP);

  // Word aligned destination; a 16-bit byte address spans the lower 32K words.
  wire logic [NNP_DATA_W-1:0] faddr_al = file_addr & NNP_FILE_ADDR_MASK;

  // Flag set for the chosen operand size, packed in flag bus order.
  wire logic [NNP_FLAG_W-1:0] neg_flags = byte_mode ?
    {dc8, n8, ov8, z8, c8} : {dc16, n16, ov16, z16, c16};
  wire logic [NNP_DATA_W-1:0] neg_res = byte_mode ? {8'h00, neg8} : neg16;

  // Pop sequence: decrement, then read the new stack top, then wait for the word.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      NNP_ST_IDLE: begin
        if (do_pop) begin
          state_nxt = NNP_ST_READ;
        end
      end
      NNP_ST_READ: begin
        state_nxt = NNP_ST_WAIT;
      end
      NNP_ST_WAIT: begin
        if (mem_rvalid) begin
          state_nxt = NNP_ST_IDLE;
        end
      end
      default: begin
        state_nxt = NNP_ST_IDLE;
      end
    endcase
  end

  // State and captured pop operands.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= NNP_ST_IDLE;
      pop_file_r <= 1'b0;
      faddr_r <= NNP_RST_WORD;
      sp_r <= NNP_RST_WORD;
    end else begin
      state_r <= state_nxt;
      if (do_pop) begin
        pop_file_r <= (op_code == NNP_OP_POP_F);
        faddr_r <= faddr_al;
        sp_r <= sp_dec;
      end
    end
  end

  // Stack pointer write lands one cycle before the memory read is issued.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sp_we_r <= 1'b0;
      mem_re_r <= 1'b0;
      raddr_r <= NNP_RST_WORD;
    end else begin
      sp_we_r <= do_pop;
      mem_re_r <= (state_r == NNP_ST_READ);
      if (state_r == NNP_ST_READ) begin
        raddr_r <= sp_r;
      end
    end
  end

  // Popped word goes to the file register or to the destination working register.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_we_r <= 1'b0;
      waddr_r <= NNP_RST_WORD;
      wdata_r <= NNP_RST_WORD;
    end else begin
      mem_we_r <= pop_end & pop_file_r;
      if (pop_end & pop_file_r) begin
        waddr_r <= faddr_r;
        wdata_r <= mem_rdata;
      end
    end
  end

  // Working register and flag writes from negate or register pop.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dest_we_r <= 1'b0;
      dest_byte_r <= 1'b0;
      dest_r <= NNP_RST_WORD;
      flags_we_r <= 1'b0;
      flags_r <= NNP_RST_FLAGS;
    end else begin
      dest_we_r <= do_neg_w | (pop_end & ~pop_file_r);
      flags_we_r <= do_neg_w;
      if (do_neg_w) begin
        dest_byte_r <= byte_mode;
        dest_r <= neg_res;
        flags_r <= neg_flags;
      end else if (pop_end & ~pop_file_r) begin
        dest_byte_r <= 1'b0;
        dest_r <= mem_rdata;
      end
    end
  end

  // Accumulator write back and completion.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_a_we_r <= 1'b0;
      acc_b_we_r <= 1'b0;
      acc_r <= NNP_RST_ACC;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      acc_a_we_r <= do_neg_acc & ~acc_sel_b;
      acc_b_we_r <= do_neg_acc & acc_sel_b;
      if (do_neg_acc) begin
        acc_r <= neg40;
      end
      done_r <= do_neg_w | do_neg_acc | do_nop | pop_end;
      busy_r <= (state_nxt != NNP_ST_IDLE);
    end
  end

  assign busy = busy_r;
  assign done = done_r;
  assign dest_we = dest_we_r;
  assign dest_byte = dest_byte_r;
  assign dest_working_reg = dest_r;
  assign flags_we = flags_we_r;
  assign flags = flags_r;
  assign acc_a_we = acc_a_we_r;
  assign acc_b_we = acc_b_we_r;
  assign acc_wdata = acc_r;
  assign sp_we = sp_we_r;
  assign sp_wdata = sp_r;
  assign mem_re = mem_re_r;
  assign mem_raddr = raddr_r;
  assign mem_we = mem_we_r;
  assign mem_waddr = waddr_r;
  assign mem_wdata = wdata_r;

endmodule // nnp_exec

//--- nnp_exec_properties.sv
// Concurrent checks on the negate, no-operation and pop execution unit.
`timescale 1ns/100ps
module nnp_exec_properties
  import nnp_pkg::*;
(
  input wire logic core_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic op_valid, // Issue.
  input wire nnp_pkg::nnp_op_e op_code, // Opcode.
  input wire logic byte_mode, // Byte size.
  input wire logic [15:0] source_working_reg, // Operand.
  input wire logic acc_sel_b, // Accumulator select.
  input wire logic [39:0] accumulator_a, // Accumulator A.
  input wire logic [39:0] accumulator_b, // Accumulator B.
  input wire logic [15:0] file_addr, // Pop target.
  input wire logic [15:0] stack_pointer_register, // Stack pointer.
  input wire logic [15:0] mem_rdata, // Read data.
  input wire logic mem_rvalid, // Read valid.
  input wire logic busy, // Busy.
  input wire logic dest_we, // Register write.
  input wire logic dest_byte, // Byte write.
  input wire logic [15:0] dest_working_reg, // Register data.
  input wire logic flags_we, // Flag write.
  input wire logic [4:0] flags, // Flags.
  input wire logic acc_a_we, // Write A.
  input wire logic acc_b_we, // Write B.
  input wire logic [39:0] acc_wdata, // Accumulator data.
  input wire logic sp_we, // Stack pointer write.
  input wire logic [15:0] sp_wdata, // New stack pointer.
  input wire logic mem_re, // Read strobe.
  input wire logic [15:0] mem_raddr, // Read address.
  input wire logic mem_we, // Write strobe.
  input wire logic [15:0] mem_waddr, // Write address.
  input wire logic [15:0] mem_wdata // Write data.
);
  logic [15:0] src_q;
  logic [15:0] fa_q;
  wire issue = op_valid && !busy;
  wire [15:0] neg_w = 16'h0000 - src_q;
  // Expected flags as {DC, N, OV, Z, C}; byte size looks at the low byte only.
  wire [4:0] fl_w = {src_q[3:0] == 4'h0, neg_w[15], src_q == 16'h8000, src_q == 16'h0000,
    src_q == 16'h0000};
  wire [4:0] fl_b = {src_q[3:0] == 4'h0, neg_w[7], src_q[7:0] == 8'h80, src_q[7:0] == 8'h00,
    src_q[7:0] == 8'h00};

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Keep the issue-time operand and target, since the inputs may move on meanwhile.
  always_ff @(posedge core_clk) src_q <= source_working_reg;
  always_ff @(posedge core_clk) if (issue && op_code == NNP_OP_POP_F) fa_q <= file_addr;

  property p_acc_sel;
    issue && op_code == NNP_OP_NEG_ACC |=> acc_b_we == $past(acc_sel_b) && acc_a_we != acc_b_we;
  endproperty
  a_acc_sel: assert property (p_acc_sel) else $error("wrong accumulator written");
  property p_acc_val;
    issue && op_code == NNP_OP_NEG_ACC |=> acc_wdata == ($past(acc_sel_b) ?
      40'h00_0000_0000 - $past(accumulator_b) : 40'h00_0000_0000 - $past(accumulator_a));
  endproperty
  a_acc_val: assert property (p_acc_val) else $error("accumulator negation wrong");
  property p_pop_sp;
    issue && (op_code == NNP_OP_POP_F || op_code == NNP_OP_POP_W) |=> sp_we &&
      sp_wdata == $past(stack_pointer_register) - NNP_SP_STEP ##1 mem_re && mem_raddr == sp_wdata;
  endproperty
  a_pop_sp: assert property (p_pop_sp) else $error("pop pointer sequence wrong");
  property p_rd_after_sp;
    mem_re |-> $past(sp_we);
  endproperty
  a_rd_after_sp: assert property (p_rd_after_sp) else $error("read before decrement");
  property p_pop_data;
    mem_we |-> $past(mem_rvalid) && mem_wdata == $past(mem_rdata);
  endproperty
  a_pop_data: assert property (p_pop_data) else $error("popped word wrong");
  property p_pop_addr;
    mem_we |-> mem_waddr == (fa_q & NNP_FILE_ADDR_MASK);
  endproperty
  a_pop_addr: assert property (p_pop_addr) else $error("pop target address wrong");
  property p_neg_w;
    issue && op_code == NNP_OP_NEG_W && !byte_mode |=> dest_we && flags_we && !dest_byte &&
      dest_working_reg == neg_w && flags == fl_w;
  endproperty
  a_neg_w: assert property (p_neg_w) else $error("word negate wrong");
  property p_neg_b;
    issue && op_code == NNP_OP_NEG_W && byte_mode |=> dest_we && flags_we && dest_byte &&
      dest_working_reg == {8'h00, neg_w[7:0]} && flags == fl_b;
  endproperty
  a_neg_b: assert property (p_neg_b) else $error("byte negate wrong");

  c_pop: cover property (mem_we);
  c_acc_b: cover property (acc_b_we);
  c_byte: cover property (dest_we && dest_byte);
endmodule // nnp_exec_properties

bind nnp_exec nnp_exec_properties i_nnp_exec_properties (.core_clk, .rst, .op_valid, .op_code,
  .byte_mode, .source_working_reg, .acc_sel_b, .accumulator_a, .accumulator_b, .file_addr,
  .stack_pointer_register, .mem_rdata, .mem_rvalid, .busy, .dest_we, .dest_byte,
  .dest_working_reg, .flags_we, .flags, .acc_a_we, .acc_b_we, .acc_wdata, .sp_we, .sp_wdata,
  .mem_re, .mem_raddr, .mem_we, .mem_waddr, .mem_wdata);

//--- test_negate_nop_pop_execution.sv
// Self-checking testbench for the negate, no-operation and pop execution unit.
`timescale 1ns/100ps
module test_negate_nop_pop_execution;
  import nnp_pkg::*;
  logic core_clk = 0, rst = 1, op_valid = 0, byte_mode = 0, acc_sel_b = 0, mem_rvalid = 0;
  nnp_op_e op_code = NNP_OP_NOP;
  logic [15:0] source_working_reg = 0, file_addr = 0, stack_pointer_register = 0, mem_rdata = 0;
  logic [39:0] accumulator_a = 0, accumulator_b = 0, acc_wdata;
  logic busy, done, dest_we, dest_byte, flags_we, acc_a_we, acc_b_we, sp_we, mem_re, mem_we;
  logic [15:0] dest_working_reg, sp_wdata, mem_raddr, mem_waddr, mem_wdata;
  logic [4:0] flags;
  logic [15:0] tv [4] = '{16'h0000, 16'h8000, 16'h1234, 16'h0080};
  int checks = 0, mismatches = 0;

  nnp_exec i_nnp_exec (.core_clk, .rst, .op_valid, .op_code, .byte_mode, .source_working_reg,
    .acc_sel_b, .accumulator_a, .accumulator_b, .file_addr, .stack_pointer_register, .mem_rdata,
    .mem_rvalid, .busy, .done, .dest_we, .dest_byte, .dest_working_reg, .flags_we, .flags,
    .acc_a_we, .acc_b_we, .acc_wdata, .sp_we, .sp_wdata, .mem_re, .mem_raddr, .mem_we,
    .mem_waddr, .mem_wdata);

  // Free-running 100 MHz clock.
  always #5 core_clk = ~core_clk;

  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  // Inputs move 1 ns after the edge; outputs are read 1 ns after the answering edge.
  // An idle edge comes first, so the strobe is never lowered and raised in one step.
  task automatic issue(input nnp_op_e op);
    @(posedge core_clk);
    #1 op_code = op;
    op_valid = 1;
    @(posedge core_clk);
    #1 op_valid = 0;
  endtask

  // Both no-operation forms complete in one cycle and write nothing.
  task automatic t_nop();
    issue(NNP_OP_NOP);
    chk("nop", 8'h80, {done, dest_we, flags_we, acc_a_we, acc_b_we, sp_we, mem_re, mem_we});
    issue(NNP_OP_NOPR);
    chk("nopr", 8'h80, {done, dest_we, flags_we, acc_a_we, acc_b_we, sp_we, mem_re, mem_we});
    $display("t_nop end");
  endtask

  task automatic t_neg_w();
    logic [15:0] v, r, m, s;
    for (int i = 0; i < 8; i++) begin
      v = tv[i % 4];
      m = i[2] ? 16'h00FF : 16'hFFFF;
      s = m ^ (m >> 1);
      r = (16'h0000 - v) & m;
      source_working_reg = v;
      byte_mode = i[2];
      issue(NNP_OP_NEG_W);
      chk("dest", {3'b111, i[2], r}, {dest_we, flags_we, done, dest_byte, dest_working_reg});
      chk("flags", {v[3:0] == 4'h0, (r & s) != 0, (v & m) == s, r == 0, (v & m) == 0}, flags);
    end
    $display("t_neg_w end");
  endtask

  task automatic t_neg_acc();
    accumulator_a = 40'h00_3290_59C8;
    accumulator_b = 40'h80_0000_0000;
    for (int i = 0; i < 2; i++) begin
      acc_sel_b = i[0];
      issue(NNP_OP_NEG_ACC);
      chk("acc_we", {i[0], !i[0], 1'b1}, {acc_b_we, acc_a_we, done});
      chk("acc", i[0] ? 40'h80_0000_0000 : 40'hFF_CD6F_A638, acc_wdata);
    end
    $display("t_neg_acc end");
  endtask

  // Pop with a slow memory answer and a refused issue while busy.
  task automatic t_pop(input nnp_op_e op, input int d);
    stack_pointer_register = 16'h1006;
    file_addr = 16'hFFFF;
    mem_rdata = 16'h5BFE;
    @(posedge core_clk);
    #1 op_code = op;
    op_valid = 1;
    @(posedge core_clk);
    #1 chk("sp", {1'b1, 16'h1004}, {sp_we, sp_wdata});
    // The strobe stays high over a second edge, which the busy unit must ignore.
    @(posedge core_clk);
    #1 op_valid = 0;
    chk("rd", {2'b10, 16'h1004}, {mem_re, sp_we, mem_raddr});
    repeat (d) @(posedge core_clk);
    if (d > 0) #1;
    mem_rvalid = 1;
    mem_rdata = 16'hA401;
    @(posedge core_clk);
    #1 mem_rvalid = 0;
    if (op == NNP_OP_POP_F) chk("wr", {4'b1100, 16'hFFFE, 16'hA401},
      {mem_we, done, dest_we, busy, mem_waddr, mem_wdata});
    else chk("wd", {4'b0110, 16'hA401}, {mem_we, done, dest_we, busy, dest_working_reg});
    $display("t_pop end");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (2000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    #1 rst = 0;
    t_neg_w();
    t_neg_acc();
    t_nop();
    t_pop(NNP_OP_POP_F, 3);
    t_pop(NNP_OP_POP_W, 0);
    tally_and_finish();
  end
endmodule // test_negate_nop_pop_execution
